/* hdl/amr_pkg.sv */
// package: register map, field layouts and bus carriers of the alert mask register slice
package amr_pkg;

   // bus geometry
   localparam int DATA_W = 32;
   localparam int ADR_W  = 10;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_MASK_TWO     = 8'h75;
   localparam logic [7:0] IDX_VOLT_LOW     = 8'h76;
   localparam logic [7:0] IDX_MIXED_LOW    = 8'h77;
   localparam logic [7:0] IDX_CONFIG_THREE = 8'h78;
   localparam logic [7:0] IDX_VOLT_HIGH    = 8'h20;
   localparam logic [7:0] IDX_MIXED_HIGH   = 8'h24;
   localparam logic [7:0] IDX_IRQ_STATUS   = 8'h90;
   localparam logic [7:0] IDX_IRQ_CLEAR    = 8'h91;
   localparam logic [7:0] IDX_IRQ_ENABLE   = 8'h92;
   localparam logic [7:0] IDX_PIN_SETUP    = 8'h93;

   // reset values
   localparam logic [7:0] MASK_TWO_RESET     = 8'h00;
   localparam logic [7:0] CONFIG_THREE_RESET = 8'h00;
   localparam logic [7:0] IRQ_ENABLE_RESET   = 8'h00;
   localparam logic [7:0] PIN_SETUP_RESET    = 8'h01;
   localparam logic [7:0] LOW_BITS_RESET     = 8'h00;

   // measurement geometry
   localparam int CHANNELS     = 4;
   localparam int RESULT_WIDTH = 10;
   localparam int LOW_FIELD_W  = 2;
   localparam int BYTE_W       = 8;

   // mask layout, shared by the sticky status and enable registers
   typedef struct packed {
      logic remote_two_diode_mask;
      logic remote_one_diode_mask;
      logic fan_four_or_timer_mask;
      logic fan_three_fault_mask;
      logic fan_two_fault_mask;
      logic fan_one_fault_mask;
      logic summary_limit_mask;
      logic twelve_volt_mask;
   } amr_mask_type;

   typedef struct packed {
      logic [6:0] other;
      logic       alert_enable;
   } amr_config_three_type;

   typedef struct packed {
      logic [5:0] other;
      logic       pin14_thermal;
      logic       twelve_volt_mode;
   } amr_pin_setup_type;

   // raw fault conditions from the monitor core
   typedef struct packed {
      logic remote_two_diode;
      logic remote_one_diode;
      logic thermal_timer;
      logic fan_four;
      logic fan_three;
      logic fan_two;
      logic fan_one;
      logic summary_limit_flag;
      logic twelve_volt_limit;
   } amr_fault_type;

   typedef struct packed {
      logic              cyc;
      logic              stb;
      logic              we;
      logic [ADR_W-1:0]  adr;
      logic [3:0]        sel;
      logic [DATA_W-1:0] dat;
   } amr_wb_req_type;

   typedef struct packed {
      logic              ack;
      logic [DATA_W-1:0] dat;
   } amr_wb_rsp_type;

   function automatic logic amr_hits(amr_wb_req_type r, logic [7:0] idx);
      return (r.adr[1:0] == 2'h0) && (r.adr[ADR_W-1:2] == idx);
   endfunction

endpackage

/* hdl/amr_alert_gate.sv */
// alert source mapping and masked alert level
`timescale 1ns/1ps
module amr_alert_gate (
   // clock and reset
   input  wire logic                       clk,
   input  wire logic                       rst,
   // sources and setup
   input  wire amr_pkg::amr_fault_type     faults,
   input  wire amr_pkg::amr_pin_setup_type pin_setup,
   input  wire amr_pkg::amr_mask_type      mask,
   input  wire amr_pkg::amr_mask_type      status,
   // results
   output amr_pkg::amr_mask_type           events,
   output logic                            alert
);
   logic next_alert;

   always_comb begin
      events = '0;
      // the channel only exists while the pin measures twelve volts
      events.twelve_volt_mask = faults.twelve_volt_limit & pin_setup.twelve_volt_mode;
      events.summary_limit_mask = faults.summary_limit_flag;
      events.fan_one_fault_mask = faults.fan_one;
      events.fan_two_fault_mask = faults.fan_two;
      events.fan_three_fault_mask = faults.fan_three;
      events.fan_four_or_timer_mask = pin_setup.pin14_thermal ? faults.thermal_timer
                                                              : faults.fan_four;
      events.remote_one_diode_mask = faults.remote_one_diode;
      events.remote_two_diode_mask = faults.remote_two_diode;
   end

   // mask gates only the alert, never the status itself
   always_comb begin
      next_alert = |(status & ~mask);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         alert <= 1'h0;
      end else begin
         alert <= next_alert;
      end
   end

endmodule

/* hdl/amr_low_bits_freeze.sv */
// low-bit register of one result group with read-triggered freeze
`timescale 1ns/1ps
module amr_low_bits_freeze #(
   parameter int WIDTH = amr_pkg::RESULT_WIDTH,
   parameter int N     = amr_pkg::CHANNELS
) (
   // clock and reset
   input  wire logic                           clk,
   input  wire logic                           rst,
   // new results
   input  wire logic [N-1:0][WIDTH-1:0]        results,
   input  wire logic                           update,
   // read strobes
   input  wire logic                           read_low,
   input  wire logic [N-1:0]                   read_high,
   // held values
   output logic [N*amr_pkg::LOW_FIELD_W-1:0]   low_bits,
   output logic [N-1:0][WIDTH-3:0]             high_bits,
   output logic                                frozen
);
   localparam int LW = amr_pkg::LOW_FIELD_W;

   logic [N-1:0]                 pending;
   logic [N-1:0]                 next_pending;
   logic [N*LW-1:0]              next_low_bits;
   logic [N-1:0][WIDTH-3:0]      next_high_bits;

   always_comb begin
      next_pending = pending & ~read_high;
      if (read_low) begin
         next_pending = '1;
      end
      next_low_bits  = low_bits;
      next_high_bits = high_bits;
      // a conversion landing on the freezing read is dropped to keep pairs coherent
      if (update && !frozen && !read_low) begin
         for (int i = 0; i < N; i++) begin
            next_low_bits[i*LW +: LW] = results[i][LW-1:0];
            next_high_bits[i]         = results[i][WIDTH-1:LW];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pending   <= '0;
         low_bits  <= '0;
         high_bits <= '0;
      end else begin
         pending   <= next_pending;
         low_bits  <= next_low_bits;
         high_bits <= next_high_bits;
      end
   end

   assign frozen = |pending;

endmodule

/* hdl/amr_top.sv */
// alert mask, extended resolution and shared pin register slice on classic wishbone
// Notes on behaviour
// - mask bit 0 blocks twelve volt limit alert while pin measures twelve volts
// - mask bit 1 blocks alerts caused by the summary limit flag
// - mask bits 2, 3, 4 block fan one, two, three fault alerts
// - mask bit 5 blocks fan four or thermal timer alert per pin mode
// - mask bits 6, 7 block remote one and two diode fault alerts
// - second mask register reads zero after reset
// - first low-bit register read-only: 2.5 V, core, supply, 5 V fields
// - second low-bit register read-only: 12 V, remote one, local, remote two
// - reading low bits freezes them and matching high bytes until read
// - config three bit 0 selects alert output or fan two drive on shared pin
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps
module amr_top #(
   parameter int RESULT_WIDTH = amr_pkg::RESULT_WIDTH
) (
   // clock and reset
   input  wire logic                                       clk,
   input  wire logic                                       rst,
   // wishbone slave
   input  wire amr_pkg::amr_wb_req_type                    wb_req,
   output amr_pkg::amr_wb_rsp_type                         wb_rsp,
   // fault conditions
   input  wire amr_pkg::amr_fault_type                     faults,
   // conversion results
   input  wire logic [amr_pkg::CHANNELS-1:0][RESULT_WIDTH-1:0] voltage_results,
   input  wire logic [amr_pkg::CHANNELS-1:0][RESULT_WIDTH-1:0] mixed_results,
   input  wire logic                                       results_update,
   // shared pin
   input  wire logic                                       fan_two_drive_output,
   output logic                                            shared_pin_out,
   output logic                                            shared_pin_oe_n,
   // interrupt
   output logic                                            irq
);
   localparam int N  = amr_pkg::CHANNELS;
   localparam int HW = RESULT_WIDTH - amr_pkg::LOW_FIELD_W;

   // high bytes must fit a register and leave the two low bits
   if (RESULT_WIDTH < 3 || HW > amr_pkg::BYTE_W) begin : g_bad_width
      $error("RESULT_WIDTH must lie between 3 and 10");
   end

   // each low-bit register packs one two-bit field per channel into one byte
   if (N * amr_pkg::LOW_FIELD_W != amr_pkg::BYTE_W) begin : g_bad_lanes
      $error("low-bit fields of all channels must fill one byte");
   end

   // bus request decode
   logic req_live;
   logic commit_wr;
   logic commit_rd;
   logic lane_ok;
   logic take_rd;

   // registers
   amr_pkg::amr_mask_type         mask_two;
   amr_pkg::amr_mask_type         next_mask_two;
   amr_pkg::amr_config_three_type config_three;
   amr_pkg::amr_config_three_type next_config_three;
   amr_pkg::amr_pin_setup_type    pin_setup;
   amr_pkg::amr_pin_setup_type    next_pin_setup;
   amr_pkg::amr_mask_type         irq_status;
   amr_pkg::amr_mask_type         next_irq_status;
   amr_pkg::amr_mask_type         irq_enable;
   amr_pkg::amr_mask_type         next_irq_enable;
   amr_pkg::amr_mask_type         irq_clear;
   amr_pkg::amr_wb_rsp_type       next_wb_rsp;
   logic                          next_irq;
   logic                          next_pin_out;
   logic                          next_pin_oe_n;

   // alert gate
   amr_pkg::amr_mask_type         events;
   logic                          alert;

   // low-bit groups
   logic                          rd_volt_low;
   logic                          rd_mixed_low;
   logic [N-1:0]                  rd_volt_high;
   logic [N-1:0]                  rd_mixed_high;
   logic [N*amr_pkg::LOW_FIELD_W-1:0] volt_low;
   logic [N*amr_pkg::LOW_FIELD_W-1:0] mixed_low;
   logic [N-1:0][HW-1:0]          volt_high;
   logic [N-1:0][HW-1:0]          mixed_high;
   logic                          volt_frozen;
   logic                          mixed_frozen;

   logic [amr_pkg::BYTE_W-1:0]    read_byte;

   function automatic logic [amr_pkg::BYTE_W-1:0] widen(logic [HW-1:0] v);
      logic [amr_pkg::BYTE_W-1:0] b;
      b = '0;
      b[HW-1:0] = v;
      return b;
   endfunction

   // ack rises one cycle after the request, effects land on the edge that samples it
   always_comb begin
      req_live  = wb_req.cyc & wb_req.stb;
      lane_ok   = wb_req.sel[0];
      take_rd   = req_live & ~wb_rsp.ack & ~wb_req.we;
      commit_wr = req_live & wb_rsp.ack & wb_req.we & lane_ok;
      commit_rd = req_live & wb_rsp.ack & ~wb_req.we;
   end

   // low-bit reads freeze on the taking edge, so no update lands under the returned byte
   // high-byte reads release on the ack edge, after their data is already registered
   always_comb begin
      rd_volt_low  = take_rd & amr_pkg::amr_hits(wb_req, amr_pkg::IDX_VOLT_LOW);
      rd_mixed_low = take_rd & amr_pkg::amr_hits(wb_req, amr_pkg::IDX_MIXED_LOW);
      for (int i = 0; i < N; i++) begin
         rd_volt_high[i]  = commit_rd & amr_pkg::amr_hits(wb_req,
                               amr_pkg::IDX_VOLT_HIGH + 8'(i));
         rd_mixed_high[i] = commit_rd & amr_pkg::amr_hits(wb_req,
                               amr_pkg::IDX_MIXED_HIGH + 8'(i));
      end
   end

   // read mux; unmapped and write-only locations read zero
   // decoded from the live address, so the byte is ready at the taking edge
   always_comb begin
      read_byte = '0;
      if (amr_pkg::amr_hits(wb_req, amr_pkg::IDX_MASK_TWO)) begin
         read_byte = mask_two;
      end
      if (amr_pkg::amr_hits(wb_req, amr_pkg::IDX_VOLT_LOW)) begin
         read_byte = volt_low;
      end
      if (amr_pkg::amr_hits(wb_req, amr_pkg::IDX_MIXED_LOW)) begin
         read_byte = mixed_low;
      end
      if (amr_pkg::amr_hits(wb_req, amr_pkg::IDX_CONFIG_THREE)) begin
         read_byte = config_three;
      end
      if (amr_pkg::amr_hits(wb_req, amr_pkg::IDX_IRQ_STATUS)) begin
         read_byte = irq_status;
      end
      if (amr_pkg::amr_hits(wb_req, amr_pkg::IDX_IRQ_ENABLE)) begin
         read_byte = irq_enable;
      end
      if (amr_pkg::amr_hits(wb_req, amr_pkg::IDX_PIN_SETUP)) begin
         read_byte = pin_setup;
      end
      for (int i = 0; i < N; i++) begin
         if (amr_pkg::amr_hits(wb_req, amr_pkg::IDX_VOLT_HIGH + 8'(i))) begin
            read_byte = widen(volt_high[i]);
         end
         if (amr_pkg::amr_hits(wb_req, amr_pkg::IDX_MIXED_HIGH + 8'(i))) begin
            read_byte = widen(mixed_high[i]);
         end
      end
   end

   // bus response
   // a strobe held past ack is answered again every other cycle
   always_comb begin
      next_wb_rsp     = '0;
      next_wb_rsp.ack = req_live & ~wb_rsp.ack;
      if (req_live && !wb_rsp.ack && !wb_req.we) begin
         next_wb_rsp.dat = {{(amr_pkg::DATA_W - amr_pkg::BYTE_W){1'h0}}, read_byte};
      end
   end

   // software-written registers; low-bit registers take no writes
   // misaligned and unmapped writes are dropped without an error response
   always_comb begin
      next_mask_two     = mask_two;
      next_config_three = config_three;
      next_irq_enable   = irq_enable;
      next_pin_setup    = pin_setup;
      irq_clear         = '0;
      if (commit_wr) begin
         if (amr_pkg::amr_hits(wb_req, amr_pkg::IDX_MASK_TWO)) begin
            next_mask_two = wb_req.dat[amr_pkg::BYTE_W-1:0];
         end
         if (amr_pkg::amr_hits(wb_req, amr_pkg::IDX_CONFIG_THREE)) begin
            next_config_three = wb_req.dat[amr_pkg::BYTE_W-1:0];
         end
         if (amr_pkg::amr_hits(wb_req, amr_pkg::IDX_IRQ_ENABLE)) begin
            next_irq_enable = wb_req.dat[amr_pkg::BYTE_W-1:0];
         end
         if (amr_pkg::amr_hits(wb_req, amr_pkg::IDX_PIN_SETUP)) begin
            next_pin_setup = wb_req.dat[amr_pkg::BYTE_W-1:0];
         end
         if (amr_pkg::amr_hits(wb_req, amr_pkg::IDX_IRQ_CLEAR)) begin
            irq_clear = wb_req.dat[amr_pkg::BYTE_W-1:0];
         end
      end
   end

   // sticky status: a new event beats a clear in the same cycle
   // clearing status also drops the alert, which reads the same bits
   always_comb begin
      next_irq_status = (irq_status & ~irq_clear) | events;
      next_irq        = |(irq_status & irq_enable);
   end

   // shared pin: open-drain alert pulled low, or push-pull fan two drive
   always_comb begin
      if (config_three.alert_enable) begin
         next_pin_out  = 1'h0;
         next_pin_oe_n = ~alert;
      end else begin
         next_pin_out  = fan_two_drive_output;
         next_pin_oe_n = 1'h0;
      end
   end

   // bus response registers
   always_ff @(posedge clk) begin
      if (rst) begin
         wb_rsp <= '0;
      end else begin
         wb_rsp <= next_wb_rsp;
      end
   end

   // software registers; config_three bits 7:1 are stored but drive nothing
   always_ff @(posedge clk) begin
      if (rst) begin
         mask_two     <= amr_pkg::MASK_TWO_RESET;
         config_three <= amr_pkg::CONFIG_THREE_RESET;
         irq_enable   <= amr_pkg::IRQ_ENABLE_RESET;
         pin_setup    <= amr_pkg::PIN_SETUP_RESET;
      end else begin
         mask_two     <= next_mask_two;
         config_three <= next_config_three;
         irq_enable   <= next_irq_enable;
         pin_setup    <= next_pin_setup;
      end
   end

   // status and interrupt; irq lags status by one cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_status <= '0;
         irq        <= 1'h0;
      end else begin
         irq_status <= next_irq_status;
         irq        <= next_irq;
      end
   end

   // shared pin registers
   always_ff @(posedge clk) begin
      if (rst) begin
         shared_pin_out  <= 1'h0;
         shared_pin_oe_n <= 1'h0;
      end else begin
         shared_pin_out  <= next_pin_out;
         shared_pin_oe_n <= next_pin_oe_n;
      end
   end

   amr_alert_gate u_alert_gate (
      .clk       (clk),
      .rst       (rst),
      .faults    (faults),
      .pin_setup (pin_setup),
      .mask      (mask_two),
      .status    (irq_status),
      .events    (events),
      .alert     (alert)
   );

   // 2.5 V, core, supply, 5 V
   amr_low_bits_freeze #(
      .WIDTH (RESULT_WIDTH),
      .N     (N)
   ) u_volt_group (
      .clk       (clk),
      .rst       (rst),
      .results   (voltage_results),
      .update    (results_update),
      .read_low  (rd_volt_low),
      .read_high (rd_volt_high),
      .low_bits  (volt_low),
      .high_bits (volt_high),
      .frozen    (volt_frozen)
   );

   // 12 V, remote one, local, remote two
   amr_low_bits_freeze #(
      .WIDTH (RESULT_WIDTH),
      .N     (N)
   ) u_mixed_group (
      .clk       (clk),
      .rst       (rst),
      .results   (mixed_results),
      .update    (results_update),
      .read_low  (rd_mixed_low),
      .read_high (rd_mixed_high),
      .low_bits  (mixed_low),
      .high_bits (mixed_high),
      .frozen    (mixed_frozen)
   );

endmodule

/* dv/amr_top_monitor.sv */
// assertion checker for the alert mask register slice
`timescale 1ns/1ps
module amr_top_monitor #(
   parameter int RESULT_WIDTH = amr_pkg::RESULT_WIDTH
) (
   // clock and reset
   input wire logic                         clk,
   input wire logic                         rst,
   // register bus
   input wire amr_pkg::amr_wb_req_type      wb_req,
   input wire amr_pkg::amr_wb_rsp_type      wb_rsp,
   // sources and results
   input wire amr_pkg::amr_fault_type       faults,
   input wire logic [3:0][RESULT_WIDTH-1:0] voltage_results,
   input wire logic [3:0][RESULT_WIDTH-1:0] mixed_results,
   input wire logic                         results_update,
   // shared pin and interrupt
   input wire logic                         fan_two_drive_output,
   input wire logic                         shared_pin_out,
   input wire logic                         shared_pin_oe_n,
   input wire logic                         irq
);
   amr_pkg::amr_wb_req_type req_q;
   logic [7:0]              mask_sh;
   logic [7:0]              cfg_sh;
   logic                    wr_ok;
   logic                    rd_ok;
   assign wr_ok = wb_rsp.ack && req_q.cyc && req_q.stb && req_q.we && req_q.sel[0];
   assign rd_ok = wb_rsp.ack && req_q.cyc && !req_q.we;
   // shadows follow bus writes only, so they never copy the design's own state
   always_ff @(posedge clk) begin
      if (rst) begin
         req_q   <= '0;
         mask_sh <= 8'h00;
         cfg_sh  <= 8'h00;
      end else begin
         if (!wb_rsp.ack) begin
            req_q <= wb_req;
         end
         if (wr_ok && req_q.adr == {amr_pkg::IDX_MASK_TWO, 2'b00}) begin
            mask_sh <= req_q.dat[7:0];
         end
         if (wr_ok && req_q.adr == {amr_pkg::IDX_CONFIG_THREE, 2'b00}) begin
            cfg_sh <= req_q.dat[7:0];
         end
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   AST_ACK_NEXT: assert property (wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack)
      else $error("request not acknowledged in the next cycle");
   AST_ACK_PULSE: assert property (wb_rsp.ack |=> !wb_rsp.ack)
      else $error("ack longer than one cycle");
   AST_DAT_IDLE: assert property (!wb_rsp.ack |-> wb_rsp.dat == 32'h0000_0000)
      else $error("read data outside ack cycle");
   AST_DAT_UPPER: assert property (wb_rsp.ack |-> wb_rsp.dat[31:8] == 24'h00_0000)
      else $error("upper read data bits set");
   AST_MASK_READBACK: assert property (rd_ok && req_q.adr == {amr_pkg::IDX_MASK_TWO, 2'b00}
      |-> wb_rsp.dat[7:0] == mask_sh)
      else $error("mask register readback differs from last write");
   AST_PWM_PASS: assert property (!cfg_sh[0] && !$past(cfg_sh[0]) && !$past(rst)
      |-> !shared_pin_oe_n && shared_pin_out == $past(fan_two_drive_output))
      else $error("shared pin does not carry fan drive");
   AST_ALERT_LOW: assert property (cfg_sh[0] && $past(cfg_sh[0]) |-> !shared_pin_out)
      else $error("alert pin drives high");
   AST_ALL_MASKED: assert property (cfg_sh[0] && $past(cfg_sh[0]) && mask_sh == 8'hFF
      && $past(mask_sh) == 8'hFF && $past(mask_sh, 2) == 8'hFF |-> shared_pin_oe_n)
      else $error("alert asserted with every source masked");
endmodule
bind amr_top amr_top_monitor #(.RESULT_WIDTH(RESULT_WIDTH)) amr_top_monitor_i (
   .clk(clk), .rst(rst), .wb_req(wb_req), .wb_rsp(wb_rsp), .faults(faults),
   .voltage_results(voltage_results), .mixed_results(mixed_results),
   .results_update(results_update), .fan_two_drive_output(fan_two_drive_output),
   .shared_pin_out(shared_pin_out), .shared_pin_oe_n(shared_pin_oe_n), .irq(irq));

/* dv/amr_host_model.sv */
// host bus master model reaching the register slice
`timescale 1ns/1ps
module amr_host_model (
   // clock
   input wire logic                    clk,
   // register bus
   output amr_pkg::amr_wb_req_type     wb_req,
   input wire amr_pkg::amr_wb_rsp_type wb_rsp
);
   initial begin
      wb_req = '0;
   end
   task automatic xfer(input logic we, input logic [9:0] adr, input logic [3:0] sel,
                       input logic [7:0] wd, output logic [7:0] rd);
      amr_pkg::amr_wb_req_type r;
      r = '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: {24'h00_0000, wd}};
      @(posedge clk);
      wb_req <= r;
      do @(posedge clk); while (wb_rsp.ack !== 1'b1);
      rd = wb_rsp.dat[7:0];
      // released lines show the inverse so stale values cannot pass for live ones
      r = '{cyc: 1'b0, stb: 1'b0, we: ~we, adr: ~adr, sel: ~sel, dat: ~r.dat};
      wb_req <= r;
   endtask
endmodule

/* dv/amr_top_tb_top.sv */
// self-checking bench of the alert mask register slice
`timescale 1ns/1ps
module amr_top_tb_top;
   logic                    clk;
   logic                    rst;
   amr_pkg::amr_wb_req_type wb_req;
   amr_pkg::amr_wb_rsp_type wb_rsp;
   amr_pkg::amr_fault_type  faults;
   logic [3:0][9:0]         volt;
   logic [3:0][9:0]         mixed;
   logic                    upd;
   logic                    fan_pwm;
   logic                    pin_out;
   logic                    pin_oe_n;
   logic                    irq;
   int                      n_fail = 0;
   int                      n_tests = 0;
   int                      cycles = 0;
   amr_top amr_top_i (.clk(clk), .rst(rst), .wb_req(wb_req), .wb_rsp(wb_rsp), .faults(faults),
      .voltage_results(volt), .mixed_results(mixed), .results_update(upd),
      .fan_two_drive_output(fan_pwm), .shared_pin_out(pin_out), .shared_pin_oe_n(pin_oe_n),
      .irq(irq));
   amr_host_model amr_host_model_i (.clk(clk), .wb_req(wb_req), .wb_rsp(wb_rsp));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] unused;
      amr_host_model_i.xfer(1'b1, {idx, 2'b00}, 4'h1, d, unused);
   endtask
   task automatic rd(input logic [7:0] idx, output logic [7:0] d);
      amr_host_model_i.xfer(1'b0, {idx, 2'b00}, 4'h1, 8'h00, d);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   function automatic amr_pkg::amr_fault_type fault_of(input int k, input logic th);
      logic [8:0] v;
      v = (k < 5) ? 9'h001 << k : (k > 5) ? 9'h001 << (k + 1) : (th ? 9'h040 : 9'h020);
      return v;
   endfunction
   function automatic logic [7:0] lows(input logic [3:0][9:0] v);
      return {v[3][1:0], v[2][1:0], v[1][1:0], v[0][1:0]};
   endfunction
   task automatic load(input int g, input logic [3:0][9:0] v);
      if (g == 1) begin
         mixed <= v;
      end else begin
         volt <= v;
      end
      upd <= 1'b1;
      @(posedge clk);
      upd <= 1'b0;
   endtask
   task automatic t_reset_values;
      logic [7:0] d;
      wr(amr_pkg::IDX_VOLT_LOW, 8'hA5);
      wr(amr_pkg::IDX_MIXED_LOW, 8'h5A);
      rd(amr_pkg::IDX_MASK_TWO, d);
      check(d, 8'h00);
      rd(amr_pkg::IDX_VOLT_LOW, d);
      check(d, 8'h00);
      rd(amr_pkg::IDX_MIXED_LOW, d);
      check(d, 8'h00);
      rd(amr_pkg::IDX_CONFIG_THREE, d);
      check(d, 8'h00);
      // reading the low bits froze both groups; read every high byte to release them
      for (int c = 0; c < 4; c++) begin
         rd(amr_pkg::IDX_VOLT_HIGH + 8'(c), d);
         check(d, 8'h00);
         rd(amr_pkg::IDX_MIXED_HIGH + 8'(c), d);
         check(d, 8'h00);
      end
      wr(amr_pkg::IDX_MASK_TWO, 8'hA5);
      amr_host_model_i.xfer(1'b1, {amr_pkg::IDX_MASK_TWO, 2'b00}, 4'h0, 8'hFF, d);
      rd(amr_pkg::IDX_MASK_TWO, d);
      check(d, 8'hA5);
      amr_host_model_i.xfer(1'b0, {amr_pkg::IDX_MASK_TWO, 2'b01}, 4'h1, 8'h00, d);
      check(d, 8'h00);
      wr(amr_pkg::IDX_MASK_TWO, 8'h00);
      $display("test reset_values done");
   endtask
   task automatic t_masks(input logic th);
      logic [7:0] d;
      wr(amr_pkg::IDX_PIN_SETUP, {6'h00, th, 1'b1});
      wr(amr_pkg::IDX_CONFIG_THREE, 8'h01);
      wr(amr_pkg::IDX_IRQ_ENABLE, 8'hFF);
      for (int k = 0; k < 8; k++) begin
         wr(amr_pkg::IDX_MASK_TWO, 8'h01 << k);
         faults <= fault_of(k, th);
         tick(4);
         check(pin_oe_n, 1'b1);
         check(irq, 1'b1);
         rd(amr_pkg::IDX_IRQ_STATUS, d);
         faults <= '0;
         check(d, 8'h01 << k);
         wr(amr_pkg::IDX_MASK_TWO, 8'h00);
         tick(3);
         check(pin_oe_n, 1'b0);
         wr(amr_pkg::IDX_IRQ_CLEAR, 8'hFF);
         tick(3);
         check(pin_oe_n, 1'b1);
         check(irq, 1'b0);
      end
      wr(amr_pkg::IDX_MASK_TWO, 8'hFF);
      faults <= '1;
      tick(4);
      check(pin_oe_n, 1'b1);
      wr(amr_pkg::IDX_IRQ_ENABLE, 8'h00);
      faults <= '0;
      wr(amr_pkg::IDX_IRQ_CLEAR, 8'hFF);
      wr(amr_pkg::IDX_MASK_TWO, 8'h00);
      $display("test masks done");
   endtask
   task automatic t_pwm;
      wr(amr_pkg::IDX_CONFIG_THREE, 8'h00);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         fan_pwm <= i[0];
         tick(2);
         check(pin_out, i[0]);
         check(pin_oe_n, 1'b0);
      end
      $display("test pwm done");
   endtask
   task automatic t_freeze(input int g);
      logic [7:0]      d;
      logic [7:0]      lo;
      logic [7:0]      hi;
      logic [3:0][9:0] a;
      logic [3:0][9:0] b;
      lo = (g == 1) ? amr_pkg::IDX_MIXED_LOW : amr_pkg::IDX_VOLT_LOW;
      hi = (g == 1) ? amr_pkg::IDX_MIXED_HIGH : amr_pkg::IDX_VOLT_HIGH;
      a = {10'h3C6, 10'h2B9, 10'h1A4, 10'h0D7};
      b = ~a;
      @(posedge clk);
      load(g, a);
      rd(lo, d);
      check(d, lows(a));
      for (int c = 0; c < 4; c++) begin
         load(g, b);
         rd(hi + 8'(c), d);
         check(d, a[c][9:2]);
      end
      load(g, b);
      rd(lo, d);
      check(d, lows(b));
      for (int c = 0; c < 4; c++) begin
         rd(hi + 8'(c), d);
         check(d, b[c][9:2]);
      end
      $display("test freeze done");
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         n_fail++;
         report_and_stop;
      end
   end
   initial begin
      rst = 1'b1;
      faults = '0;
      volt = '0;
      mixed = '0;
      upd = 1'b0;
      fan_pwm = 1'b0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      t_reset_values;
      t_masks(1'b0);
      t_masks(1'b1);
      t_pwm;
      t_freeze(0);
      t_freeze(1);
      report_and_stop;
   end
endmodule
